// file: design/dch_channel.sv
// dma channel: apb registers, transfer sequencer, bus master and arbitration
`default_nettype none
module dch_channel #(
	parameter logic [2:0] CH_NUM = 3'h5
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic periph_req,
	input wire logic rival_req,
	input wire logic [2:0] rival_prio,
	input wire logic [2:0] rival_num,
	output logic bus_valid,
	output dch_pkg::dch_bus_req_t bus_out,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata,
	output logic bus_lock,
	output logic chan_req,
	output logic chan_clk_en,
	output logic irq
);
	import dch_pkg::*;

	// ==========================================================
	// registers
	logic [15:0] src_lo, src_hi, dst_lo, dst_hi;
	logic [15:0] thr, len, ctrl, idx;
	logic [31:0] data;
	logic req_prev, req_pend;
	dch_state_t state;

	// control fields
	logic on, irq_en, trig, dinc, sinc, circ, yield, fill, sense;
	logic [1:0] width;
	logic [2:0] prio;
	assign on = ctrl[B_ON];
	assign width = ctrl[B_WIDTH_LO +: 2];
	assign irq_en = ctrl[B_IRQ_EN];
	assign trig = ctrl[B_TRIGGER];
	assign dinc = ctrl[B_DST_INC];
	assign sinc = ctrl[B_SRC_INC];
	assign circ = ctrl[B_CIRCULAR];
	assign prio = ctrl[B_PRIO_LO +: 3];
	assign yield = ctrl[B_YIELD];
	assign fill = ctrl[B_FILL];
	assign sense = ctrl[B_SENSE];

	// ==========================================================
	// apb decode
	logic acc, wr_en;
	logic [29:0] wa;
	assign acc = psel && penable && pready;
	assign wr_en = acc && pwrite;
	assign wa = paddr[31:2];
	function automatic logic hit(input logic [29:0] a, input logic [31:0] ofs);
		hit = (a == ofs[29:0]);
	endfunction : hit

	logic mapped;
	logic [15:0] rd_val;
	always_comb begin
		mapped = 1'b1;
		rd_val = 16'h0000;
		if (hit(wa, OFS_SRC_LOW)) rd_val = src_lo;
		else if (hit(wa, OFS_SRC_HIGH)) rd_val = src_hi;
		else if (hit(wa, OFS_DST_LOW)) rd_val = dst_lo;
		else if (hit(wa, OFS_DST_HIGH)) rd_val = dst_hi;
		else if (hit(wa, OFS_THRESHOLD)) rd_val = thr;
		else if (hit(wa, OFS_LENGTH)) rd_val = len;
		else if (hit(wa, OFS_CONTROL)) rd_val = ctrl;
		else if (hit(wa, OFS_ITEM_INDEX)) rd_val = idx;
		else mapped = 1'b0;
	end

	// one wait state keeps pready and prdata straight from flops
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= {16'h0000, rd_val};
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// address halves and count registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			src_lo <= REG_RESET;
			src_hi <= REG_RESET;
			dst_lo <= REG_RESET;
			dst_hi <= REG_RESET;
			thr <= REG_RESET;
			len <= REG_RESET;
		end else if (wr_en) begin
			if (hit(wa, OFS_SRC_LOW)) src_lo <= pwdata[15:0];
			if (hit(wa, OFS_SRC_HIGH)) src_hi <= pwdata[15:0];
			if (hit(wa, OFS_DST_LOW)) dst_lo <= pwdata[15:0];
			if (hit(wa, OFS_DST_HIGH)) dst_hi <= pwdata[15:0];
			if (hit(wa, OFS_THRESHOLD)) thr <= pwdata[15:0];
			if (hit(wa, OFS_LENGTH)) len <= pwdata[15:0];
		end
	end

	// ==========================================================
	// sequencer helpers
	logic ack, last, fin, keep_on, req_ok, win;
	logic [1:0] sh;
	logic [31:0] step_src, step_dst;
	assign ack = bus_valid && bus_ack;
	assign last = (idx == len);
	assign fin = (state == S_WR) && ack && last;
	assign keep_on = circ && trig;
	// reserved width falls back to byte steps
	assign sh = (width == WIDTH_RESERVED) ? 2'h0 : width;
	assign step_src = sinc ? ({16'h0000, idx} << sh) : 32'h0000_0000;
	assign step_dst = dinc ? ({16'h0000, idx} << sh) : 32'h0000_0000;
	// level sense uses the line, edge sense a latched rising edge
	assign req_ok = sense ? req_pend : periph_req;
	// higher field wins, ties go to the lower channel number
	// a fill run already under way keeps the bus against every rival
	assign win = !rival_req || (fill && idx != 16'h0000)
		|| (prio > rival_prio)
		|| ((prio == rival_prio) && (CH_NUM < rival_num));

	// control word: software write wins over the self clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl <= REG_RESET;
		end else if (wr_en && hit(wa, OFS_CONTROL)) begin
			ctrl <= pwdata[15:0] & CTRL_WMASK;
		end else if (fin && !keep_on) begin
			ctrl[B_ON] <= 1'b0;
		end
	end

	// rising edge capture; a new edge wins over consumption
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			req_prev <= 1'b0;
			req_pend <= 1'b0;
		end else begin
			req_prev <= periph_req;
			if (periph_req && !req_prev) req_pend <= 1'b1;
			else if (state == S_WAIT && sense && req_pend) req_pend <= 1'b0;
			else if (!on) req_pend <= 1'b0;
		end
	end

	// item index: hardware only, software writes ignored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			idx <= REG_RESET;
		end else if (!on || state == S_IDLE) begin
			idx <= REG_RESET;
		end else if (state == S_WR && ack) begin
			idx <= last ? REG_RESET : idx + 16'h0001;
		end
	end

	// interrupt pulse after a store, tested before the increment
	always_ff @(posedge clk) begin
		if (!reset_n) irq <= 1'b0;
		else irq <= (state == S_WR) && ack && irq_en && (thr == idx);
	end

	// ==========================================================
	// transfer state machine
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= S_IDLE;
		end else if (!on) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: state <= trig ? S_WAIT : S_ARB;
				S_WAIT: if (req_ok) state <= S_ARB;
				S_ARB: begin
					// fill reads only once; later items go straight to store
					if (win) state <= (fill && idx != 16'h0000) ? S_WR : S_RD;
				end
				S_RD: if (ack) state <= S_WR;
				S_WR: begin
					if (ack) begin
						if (fin && !keep_on) state <= S_IDLE;
						else if (trig) state <= S_WAIT;
						else if (yield) state <= S_GAP;
						else state <= S_ARB;
					end
				end
				S_GAP: state <= S_ARB;
				default: state <= S_IDLE;
			endcase
		end
	end

	// bus request: address from start, index and width
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_valid <= 1'b0;
			bus_out <= '0;
		end else if (ack || !on) begin
			bus_valid <= 1'b0;
		end else if (state == S_ARB && win) begin
			bus_valid <= 1'b1;
			bus_out.size <= sh;
			if (fill && idx != 16'h0000) begin
				bus_out.we <= 1'b1;
				bus_out.addr <= {dst_hi, dst_lo} + step_dst;
				bus_out.wdata <= data;
			end else begin
				bus_out.we <= 1'b0;
				bus_out.addr <= {src_hi, src_lo} + step_src;
			end
		end else if (state == S_RD && ack) begin
			bus_valid <= 1'b0;
		end else if (state == S_WR && !bus_valid) begin
			bus_valid <= 1'b1;
			bus_out.we <= 1'b1;
			bus_out.addr <= {dst_hi, dst_lo} + step_dst;
			bus_out.wdata <= data;
		end
	end

	// read data held for the store and for the whole fill run
	always_ff @(posedge clk) begin
		if (!reset_n) data <= 32'h0000_0000;
		else if (state == S_RD && ack) data <= bus_rdata;
	end

	// lock keeps lower masters off: fill outside the request wait, blocking copies too
	always_ff @(posedge clk) begin
		if (!reset_n) bus_lock <= 1'b0;
		else bus_lock <= on && state != S_IDLE && state != S_WAIT
			&& (fill || (!yield && !trig));
	end

	// request to the arbiter and the channel clock enable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			chan_req <= 1'b0;
			chan_clk_en <= 1'b0;
		end else begin
			chan_req <= on && state == S_ARB;
			chan_clk_en <= on;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_off_idle: assert property ((state != S_IDLE) |-> $past(on))
		else $error("channel busy while off");
	a_irq_gate: assert property (irq |-> $past(irq_en))
		else $error("interrupt with enable clear");
	a_irq_match: assert property (irq |-> $past(thr == idx && state == S_WR))
		else $error("interrupt without threshold match");
	a_size_sel: assert property (bus_valid && width != WIDTH_RESERVED |-> bus_out.size == width)
		else $error("transfer size differs from width field");
	a_idx_clear: assert property (fin |=> idx == 16'h0000)
		else $error("index not cleared at completion");
	a_on_clear: assert property (fin && !keep_on && !wr_en |=> !on)
		else $error("on bit left set after normal run");
	a_circ_keep: assert property (fin && keep_on && !wr_en |=> on ##1 state == S_WAIT)
		else $error("circular run did not restart");
	a_start_now: assert property ($rose(on) && !trig && !wr_en |=> state == S_ARB)
		else $error("untriggered channel did not start");
	a_fill_once: assert property (state == S_RD |-> !fill || idx == 16'h0000)
		else $error("fill read source more than once");
	a_gap_yield: assert property (state == S_WR && ack && !last && yield && !trig |=> state == S_GAP)
		else $error("no wait cycle after store");
	a_prio_hold: assert property (state == S_ARB && rival_req && rival_prio > prio
		&& !(fill && idx != 16'h0000) |=> state == S_ARB)
		else $error("lower priority took the bus");
	a_src_addr: assert property ($rose(bus_valid) && !bus_out.we |-> bus_out.addr == {src_hi, src_lo} + $past(step_src))
		else $error("source address wrong");

	c_normal_done: cover property (fin && !keep_on);
	c_circular: cover property (fin && keep_on);
	c_fill_store: cover property (fill && state == S_WR && idx == 16'h0002);
	c_irq: cover property (irq);
endmodule : dch_channel
`default_nettype wire

// file: design/dch_pkg.sv
// package: register map, control fields and types of the dma channel
// ==========================================================
`default_nettype none
package dch_pkg;
	// ==========================================================
	// register indices (printed offsets), byte address is four times
	localparam logic [31:0] OFS_CH4_CONTROL = 32'h5000354c;
	localparam logic [31:0] OFS_CH4_ITEM_INDEX = 32'h5000354e;
	localparam logic [31:0] OFS_SRC_LOW = 32'h50003550;
	localparam logic [31:0] OFS_SRC_HIGH = 32'h50003552;
	localparam logic [31:0] OFS_DST_LOW = 32'h50003554;
	localparam logic [31:0] OFS_DST_HIGH = 32'h50003556;
	localparam logic [31:0] OFS_THRESHOLD = 32'h50003558;
	localparam logic [31:0] OFS_LENGTH = 32'h5000355a;
	localparam logic [31:0] OFS_CONTROL = 32'h5000355c;
	localparam logic [31:0] OFS_ITEM_INDEX = 32'h5000355e;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// ==========================================================
	// control word bit positions
	localparam int B_ON = 0;
	localparam int B_WIDTH_LO = 1;
	localparam int B_IRQ_EN = 3;
	localparam int B_TRIGGER = 4;
	localparam int B_DST_INC = 5;
	localparam int B_SRC_INC = 6;
	localparam int B_CIRCULAR = 7;
	localparam int B_PRIO_LO = 8;
	localparam int B_YIELD = 11;
	localparam int B_FILL = 12;
	localparam int B_SENSE = 13;
	localparam logic [15:0] CTRL_WMASK = 16'h3fff;
	localparam logic [1:0] WIDTH_RESERVED = 2'h3;
	// ==========================================================
	// bus request carried to the system bus
	typedef struct packed {
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dch_bus_req_t;
	typedef enum {
		S_IDLE, S_WAIT, S_ARB, S_RD, S_WR, S_GAP
	} dch_state_t;
endpackage : dch_pkg
`default_nettype wire

// file: testbench/dch_channel_bench.sv
// self-checking bench of the dma channel: register access and bus traffic
`default_nettype none
module dch_channel_bench;
	import dch_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, periph_req = 1'b0, rival_req = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, bus_rdata, rv;
	logic [2:0] rival_prio = 3'h0, rival_num = 3'h0;
	logic pready, pslverr, bus_valid, bus_ack, bus_lock, chan_req, chan_clk_en, irq, err;
	logic slow = 1'b0;
	logic [15:0] c;
	dch_bus_req_t bus_out;
	int fail_count = 0, compares = 0, irq_n = 0;
	always #25 clk = ~clk;
	dch_channel DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(periph_req), .rival_req(rival_req),
		.rival_prio(rival_prio), .rival_num(rival_num), .bus_valid(bus_valid),
		.bus_out(bus_out), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_lock(bus_lock),
		.chan_req(chan_req), .chan_clk_en(chan_clk_en), .irq(irq));
	dch_mem_model mem (.clk(clk), .reset_n(reset_n), .slow(slow), .bus_valid(bus_valid),
		.bus_out(bus_out), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
	// irq is a one-cycle pulse, so count it at the settled half of the cycle
	always @(negedge clk) if (irq === 1'b1) irq_n++;
	// ==========================================================
	// comparison, bus cycles and completion
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [31:0] ofs, input logic [15:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ofs << 2;
		pwdata <= {16'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		// request held until the edge that samples pready high; data taken there
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check("pready", {31'h0, pready}, 32'h1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [31:0] ofs, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, ofs, 16'h0);
		check("read data", rv, exp);
		check("slave error", {31'h0, err}, {31'h0, exp_err});
	endtask : rd
	task automatic wr(input logic [31:0] ofs, input logic [15:0] d);
		apb(1'b1, ofs, d);
	endtask : wr
	task automatic idle();
		int n;
		n = 0;
		// let the enable written at this edge settle before watching it
		@(negedge clk);
		while (chan_clk_en !== 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check("channel off", {31'h0, chan_clk_en}, 32'h0);
		@(posedge clk);
	endtask : idle
	task automatic expect_writes(input int n, input logic [31:0] sst, input logic [31:0] dstp,
			input logic [1:0] sz, input logic fill);
		check("write count", mem.wq.size(), n);
		for (int i = 0; i < n && i < mem.wq.size(); i++) begin
			check("write addr", mem.wq[i].addr, 32'h2000 + i * dstp);
			check("write data", mem.wq[i].wdata, (32'h1000 + (fill ? 0 : i * sst)) ^ 32'ha5a50000);
			check("write size", {30'h0, mem.wq[i].size}, {30'h0, sz});
		end
		mem.wq.delete();
	endtask : expect_writes
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// ==========================================================
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		summarize();
	end
	// ==========================================================
	// test sequence
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd(OFS_SRC_LOW + 2 * i, 32'h0, 1'b0);
			wr(OFS_SRC_LOW + 2 * i, 16'h1234 + 16'(i));
			rd(OFS_SRC_LOW + 2 * i, 32'h1234 + i, 1'b0);
		end
		rd(OFS_CONTROL, 32'h0, 1'b0);
		wr(OFS_CONTROL, 16'hfffe);
		rd(OFS_CONTROL, 32'h3ffe, 1'b0);
		wr(OFS_CONTROL, 16'h0);
		wr(OFS_ITEM_INDEX, 16'h5);
		rd(OFS_ITEM_INDEX, 32'h0, 1'b0);
		rd(OFS_CH4_CONTROL, 32'h0, 1'b1);
		$display("test registers done");
		wr(OFS_SRC_LOW, 16'h1000);
		wr(OFS_SRC_HIGH, 16'h0);
		wr(OFS_DST_LOW, 16'h2000);
		wr(OFS_DST_HIGH, 16'h0);
		wr(OFS_LENGTH, 16'h2);
		wr(OFS_THRESHOLD, 16'h1);
		// each width; source fixed at byte width, yield at halfword, interrupt at word
		for (int w = 0; w < 3; w++) begin
			irq_n = 0;
			mem.rd_count = 0;
			c = 16'h21 | 16'(w << 1);
			if (w > 0) c = c | 16'h40;
			if (w == 1) c = c | 16'h800;
			if (w == 2) c = c | 16'h8;
			wr(OFS_CONTROL, c);
			idle();
			expect_writes(3, w > 0 ? 1 << w : 0, 1 << w, 2'(w), 1'b0);
			check("irq count", irq_n, w == 2);
			check("read count", mem.rd_count, 3);
			rd(OFS_CONTROL, {16'h0, c & 16'hfffe}, 1'b0);
			rd(OFS_ITEM_INDEX, 32'h0, 1'b0);
		end
		$display("test widths done");
		mem.rd_count = 0;
		slow <= 1'b1;
		wr(OFS_LENGTH, 16'h3);
		wr(OFS_CONTROL, 16'h1063); // fill kept apart from peripheral trigger
		idle();
		expect_writes(4, 0, 2, 2'h1, 1'b1);
		check("read count", mem.rd_count, 1);
		slow <= 1'b0;
		$display("test fill done");
		wr(OFS_LENGTH, 16'h0);
		rival_req <= 1'b1;
		rival_prio <= 3'h4;
		wr(OFS_CONTROL, 16'h0361);
		repeat (20) @(negedge clk);
		check("writes outranked", mem.wq.size(), 0);
		@(posedge clk);
		rival_prio <= 3'h3;
		repeat (20) @(negedge clk);
		check("writes on tie", mem.wq.size(), 0);
		@(posedge clk);
		rival_num <= 3'h7;
		idle();
		expect_writes(1, 0, 0, 2'h0, 1'b0);
		rival_req <= 1'b0;
		$display("test priority done");
		wr(OFS_CONTROL, 16'h20b1);
		repeat (20) @(negedge clk);
		check("writes before request", mem.wq.size(), 0);
		@(posedge clk);
		periph_req <= 1'b1;
		repeat (40) @(negedge clk);
		check("writes per edge", mem.wq.size(), 1);
		@(posedge clk);
		periph_req <= 1'b0;
		@(posedge clk);
		periph_req <= 1'b1;
		repeat (40) @(negedge clk);
		expect_writes(2, 0, 0, 2'h0, 1'b0);
		@(posedge clk);
		rd(OFS_CONTROL, 32'h20b1, 1'b0);
		wr(OFS_CONTROL, 16'h0);
		@(negedge clk);
		check("clock enable", chan_clk_en, 1'b0);
		periph_req <= 1'b0;
		$display("test trigger done");
		summarize();
	end
endmodule : dch_channel_bench
`default_nettype wire

// file: testbench/dch_mem_model.sv
// bus partner: memory that answers channel reads and logs channel writes
`default_nettype none
module dch_mem_model
	import dch_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic bus_valid,
	input wire dch_pkg::dch_bus_req_t bus_out,
	output logic bus_ack,
	output logic [31:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	dch_bus_req_t wq[$];
	int rd_count = 0;
	int wait_n = 0;
	// ==========================================================
	// answer promptly or after three cycles; read data follows the address
	always @(posedge clk) begin
		if (!reset_n) begin
			bus_ack <= 1'b0;
			bus_rdata <= 32'h0;
			wait_n = 0;
		end else if (bus_ack) begin
			bus_ack <= 1'b0;
			bus_rdata <= ~bus_rdata; // stale data must never look valid
			if (bus_valid && bus_out.we) begin
				wq.push_back(bus_out);
			end else if (bus_valid) begin
				rd_count++;
			end
		end else if (bus_valid) begin
			if (wait_n >= (slow ? 3 : 0)) begin
				bus_ack <= 1'b1;
				bus_rdata <= bus_out.addr ^ 32'ha5a50000;
				wait_n = 0;
			end else begin
				wait_n++;
			end
		end
	end
endmodule : dch_mem_model
`default_nettype wire
